// *** hdl/cmp_pwm_ctrl.v ***
// Purpose: Oscillator, jitter, PWM latch, soft start and blanking of the controller
// Assumes: Comparator outputs arrive synchronous to clk; supply_ok low acts as lockout
// Notes:   Analog level shaping is outside; soft-start limit is a step code out
// Function
// - 100 kHz cycles, 4 percent jitter, 4 ms
// - On time at most 375 cycles, 0.75 of nominal period
// - Jitter only after soft start completes
// - Soft start begins at lockout release
// - Step every 300 us, 32 steps
// - Soft start ends 10 ms, sink off
// - Allowed duty rises from zero gradually
// - Soft start restarts on each auto-restart
// - Oscillator sets latch, comparators reset it
// - Latch reset turns driver off immediately
// - Feedback comparator ends on-pulse
// - Current limit resets latch cycle by cycle
// - Burst limit counts only in burst mode
// - Blank sense 220 ns normal, 180 burst
// - Driver low below supply off threshold
// - Undervoltage resets soft-start counter to zero
// - Feedback turn-off waits 156 ns after set
`include "cmp_consts.vh"
module cmp_pwm_ctrl #(
    parameter PERIOD_CYC = `CMP_PERIOD_CYC,
    parameter SS_STEPS   = `CMP_SS_STEPS
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       supply_ok,
    input  wire       restart_req,
    input  wire       burst_mode,
    input  wire       fb_cmp,
    input  wire       ss_cmp,
    input  wire       current_limit_comparator,
    input  wire       burst_limit_comparator,
    output reg        gate_drive,
    output reg  [4:0] softstart_limit_level,
    output reg        ss_sink_on,
    output reg        ss_done,
    output reg        osc_max_duty
);
    // Derived cycle counts; least times round up, longest round down
    localparam integer NS_DIV      = `CMP_NS_PER_S / `CMP_CLK_HZ;
    localparam integer LEB_N_CYC   = (`CMP_LEB_NORM_NS + NS_DIV - 1) / NS_DIV;
    localparam integer LEB_B_CYC   = (`CMP_LEB_BURST_NS + NS_DIV - 1) / NS_DIV;
    localparam integer FBD_CYC     = (`CMP_FB_DLY_NS + NS_DIV - 1) / NS_DIV;
    localparam integer ON_MAX_CYC  = PERIOD_CYC * `CMP_DMAX_NUM / `CMP_DMAX_DEN;
    localparam integer JIT_CYC     = PERIOD_CYC * `CMP_JIT_PCT / 100;
    localparam integer SS_STEP_CYC = `CMP_SS_STEP_US * (`CMP_CLK_HZ / `CMP_US_PER_S);
    localparam integer SS_END_CYC  = `CMP_SS_TOTAL_MS * (`CMP_CLK_HZ / `CMP_MS_PER_S);
    localparam integer JIT_STEP_CYC = `CMP_JIT_PERIOD_US * (`CMP_CLK_HZ / `CMP_US_PER_S)
                                      / (4 * `CMP_JIT_STEPS);

    // Soft-start states, one-hot
    localparam [2:0] ST_OFF  = 3'b001;
    localparam [2:0] ST_SOFT = 3'b010;
    localparam [2:0] ST_RUN  = 3'b100;

    reg [2:0]  state_q;
    reg [9:0]  osc_cnt_q;
    reg [9:0]  period_q;
    reg [19:0] ss_tick_q;
    reg [19:0] ss_time_q;
    reg [5:0]  ss_step_q;
    reg [17:0] jit_tick_q;
    reg [6:0]  jit_pos_q;
    reg        jit_up_q;
    reg        latch_q;
    reg [9:0]  on_cnt_q;

    wire       running = (state_q != ST_OFF);
    wire       cycle_end = (osc_cnt_q >= period_q - 10'd1);
    wire       set_pulse = running && cycle_end;
    wire       leb_active;
    wire       fbd_active;
    wire [7:0] leb_len = burst_mode ? LEB_B_CYC[7:0] : LEB_N_CYC[7:0];

    // Soft-start on-time cap grows with step count
    wire [15:0] ss_on_prod = ON_MAX_CYC[9:0] * ss_step_q;
    wire [9:0]  ss_on_max  = (state_q == ST_SOFT) ? ss_on_prod[14:5] : ON_MAX_CYC[9:0];
    // Zero cap at step zero: no pulse at all, not even the set cycle
    wire        cap_zero   = (ss_on_max == 10'h000);

    // Reset sources; comparator trips only after blanking
    wire sense_ok  = !leb_active;
    wire fb_rst    = fb_cmp && sense_ok && !fbd_active;
    wire ss_rst    = ss_cmp && sense_ok && (state_q == ST_SOFT);
    wire cl_rst    = current_limit_comparator && sense_ok;
    wire bl_rst    = burst_limit_comparator && burst_mode && sense_ok;
    wire duty_rst  = (on_cnt_q >= ON_MAX_CYC[9:0] - 10'd1) ||
                     ({1'b0, on_cnt_q} + 11'h001 >= {1'b0, ss_on_max});
    wire any_rst   = fb_rst || ss_rst || cl_rst || bl_rst || duty_rst || !supply_ok;

    // Blanking after each turn-on
    cmp_blank_timer #(.W(8)) u_leb (
        .clk    (clk),
        .rst_n  (rst_n),
        .start  (set_pulse),
        .len    (leb_len),
        .active (leb_active)
    );

    // Fixed delay before feedback may act
    cmp_blank_timer #(.W(8)) u_fbd (
        .clk    (clk),
        .rst_n  (rst_n),
        .start  (set_pulse),
        .len    (FBD_CYC[7:0]),
        .active (fbd_active)
    );

    // Soft-start sequencer
    always @(posedge clk) begin
        if (!rst_n || !supply_ok) begin
            state_q   <= ST_OFF;
            ss_tick_q <= 20'h0_0000;
            ss_time_q <= 20'h0_0000;
            ss_step_q <= 6'h00;
        end else begin
            case (state_q)
                ST_OFF: begin
                    state_q   <= ST_SOFT;
                    ss_tick_q <= 20'h0_0000;
                    ss_time_q <= 20'h0_0000;
                    ss_step_q <= 6'h00;
                end
                ST_SOFT: begin
                    if (restart_req) begin
                        ss_tick_q <= 20'h0_0000;
                        ss_time_q <= 20'h0_0000;
                        ss_step_q <= 6'h00;
                    end else if (ss_time_q >= SS_END_CYC[19:0] - 20'h0_0001) begin
                        state_q <= ST_RUN;
                    end else begin
                        ss_time_q <= ss_time_q + 20'h0_0001;
                        if (ss_tick_q >= SS_STEP_CYC[19:0] - 20'h0_0001) begin
                            ss_tick_q <= 20'h0_0000;
                            if (ss_step_q < SS_STEPS[5:0])
                                ss_step_q <= ss_step_q + 6'h01;
                        end else begin
                            ss_tick_q <= ss_tick_q + 20'h0_0001;
                        end
                    end
                end
                ST_RUN: begin
                    if (restart_req) begin
                        state_q   <= ST_SOFT;
                        ss_tick_q <= 20'h0_0000;
                        ss_time_q <= 20'h0_0000;
                        ss_step_q <= 6'h00;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    // Jitter triangle, held at position 0 (period minus JIT_CYC) until soft start is over
    always @(posedge clk) begin
        if (!rst_n || state_q != ST_RUN) begin
            jit_tick_q <= 18'h0_0000;
            jit_pos_q  <= 7'h00;
            jit_up_q   <= 1'b1;
        end else if (jit_tick_q >= JIT_STEP_CYC[17:0] - 18'h0_0001) begin
            jit_tick_q <= 18'h0_0000;
            if (jit_up_q) begin
                if (jit_pos_q >= 7'd2 * `CMP_JIT_STEPS - 7'd1)
                    jit_up_q <= 1'b0;
                jit_pos_q <= jit_pos_q + 7'h01;
            end else begin
                if (jit_pos_q <= 7'h01)
                    jit_up_q <= 1'b1;
                jit_pos_q <= jit_pos_q - 7'h01;
            end
        end else begin
            jit_tick_q <= jit_tick_q + 18'h0_0001;
        end
    end

    // Jitter offset, +/- JIT_CYC around nominal period
    wire [15:0] jit_prod = JIT_CYC[7:0] * jit_pos_q;
    wire [9:0]  jit_off  = jit_prod[9:0] / `CMP_JIT_STEPS;
    wire [9:0]  period_d = PERIOD_CYC[9:0] - JIT_CYC[9:0] + jit_off;

    // Oscillator; new period latched at each cycle boundary
    always @(posedge clk) begin
        if (!rst_n || !running) begin
            osc_cnt_q <= 10'h000;
            period_q  <= PERIOD_CYC[9:0];
        end else if (cycle_end) begin
            osc_cnt_q <= 10'h000;
            period_q  <= (state_q == ST_RUN) ? period_d : PERIOD_CYC[9:0];
        end else begin
            osc_cnt_q <= osc_cnt_q + 10'h001;
        end
    end

    // PWM latch; only lockout, current limit, burst limit and zero cap win over set
    always @(posedge clk) begin
        if (!rst_n) begin
            latch_q  <= 1'b0;
            on_cnt_q <= 10'h000;
        end else if (any_rst && latch_q) begin
            latch_q  <= 1'b0;
            on_cnt_q <= 10'h000;
        end else if (set_pulse && !(!supply_ok || cl_rst || bl_rst || cap_zero)) begin
            latch_q  <= 1'b1;
            on_cnt_q <= 10'h000;
        end else if (latch_q) begin
            on_cnt_q <= on_cnt_q + 10'h001;
        end
    end

    // Registered outputs; gate falls with the latch reset decision
    always @(posedge clk) begin
        if (!rst_n) begin
            gate_drive            <= 1'b0;
            softstart_limit_level <= 5'h00;
            ss_sink_on            <= 1'b0;
            ss_done               <= 1'b0;
            osc_max_duty          <= 1'b0;
        end else begin
            gate_drive <= supply_ok && ((latch_q && !any_rst) ||
                          (set_pulse && !(cl_rst || bl_rst || cap_zero)));
            softstart_limit_level <= (ss_step_q >= SS_STEPS[5:0]) ? 5'h1F : ss_step_q[4:0];
            ss_sink_on   <= (state_q == ST_SOFT);
            ss_done      <= (state_q == ST_RUN);
            osc_max_duty <= running && (osc_cnt_q >= ON_MAX_CYC[9:0] - 10'h001);
        end
    end
endmodule // cmp_pwm_ctrl

// *** hdl/cmp_consts.vh ***
// Purpose: Shared constants for the current-mode PWM soft-start controller
// Assumes: 50 MHz clock, times given in ns, us and ms; cmp_pwm_ctrl converts them to cycles
// Notes:   Definitions only
`ifndef CMP_CONSTS_VH
`define CMP_CONSTS_VH

`define CMP_CLK_HZ          50000000
`define CMP_PERIOD_CYC      500
`define CMP_DMAX_NUM        3
`define CMP_DMAX_DEN        4
`define CMP_JIT_PCT         4
`define CMP_JIT_PERIOD_US   4000
`define CMP_JIT_STEPS       20
`define CMP_SS_STEP_US      300
`define CMP_SS_STEPS        32
`define CMP_SS_TOTAL_MS     10
`define CMP_LEB_NORM_NS     220
`define CMP_LEB_BURST_NS    180
`define CMP_FB_DLY_NS       156
`define CMP_NS_PER_S        1000000000
`define CMP_US_PER_S        1000000
`define CMP_MS_PER_S        1000

`endif

// *** hdl/cmp_blank_timer.v ***
// Purpose: Retriggerable down counter that holds a window after a start pulse
// Assumes: start is a one-cycle pulse, len is at least one
// Notes:   Used for edge blanking and the feedback turn-off delay
module cmp_blank_timer #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         start,
    input  wire [W-1:0] len,
    output wire         active
);
    reg [W-1:0] cnt_q;

    // Load on start, count to zero
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= {W{1'b0}};
        end else if (start) begin
            cnt_q <= len;
        end else if (cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign active = (cnt_q != {W{1'b0}});
endmodule // cmp_blank_timer

// *** bench/cmp_sense_model.sv ***
// Purpose: Sense-side partner: switch current ramp and comparator trips
// Assumes: Current ramps one count per cycle while the switch conducts
// Notes:   trip_at 10'h3ff keeps every comparator quiet
module cmp_sense_model (
    input  wire logic       clk,
    input  wire logic       gate_drive,
    input  wire logic [1:0] trip_sel,
    input  wire logic [9:0] trip_at,
    output logic            fb_cmp,
    output logic            ss_cmp,
    output logic            cl_cmp,
    output logic            bl_cmp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] ramp_q;
    logic       hit;
    // Ramp collapses when the switch opens, so no trip is left standing
    always_ff @(posedge clk) ramp_q <= gate_drive ? ramp_q + 10'h001 : 10'h000;
    assign hit    = gate_drive && (ramp_q >= trip_at);
    assign fb_cmp = hit && (trip_sel == 2'h0);
    assign ss_cmp = hit && (trip_sel == 2'h2);
    assign cl_cmp = hit && (trip_sel == 2'h1);
    assign bl_cmp = hit && (trip_sel == 2'h3);
endmodule // cmp_sense_model

// *** bench/cmp_pwm_monitor.sv ***
// Purpose: Port checker for the PWM controller
// Assumes: Sense inputs honoured from the 12th on cycle
// Notes:   Bound into cmp_pwm_ctrl below
module cmp_pwm_monitor (
    input wire       clk,
    input wire       rst_n,
    input wire       supply_ok,
    input wire       restart_req,
    input wire       burst_mode,
    input wire       fb_cmp,
    input wire       current_limit_comparator,
    input wire       burst_limit_comparator,
    input wire       gate_drive,
    input wire [4:0] softstart_limit_level,
    input wire       ss_done
);
    logic [9:0] on_q;
    logic [9:0] per_q;
    logic       gq_q;
    logic       pv_q;
    // On time and rise spacing; phase is forgotten on lockout or restart
    always_ff @(posedge clk) begin
        gq_q  <= gate_drive;
        on_q  <= gate_drive ? on_q + 10'h001 : 10'h000;
        per_q <= (gate_drive && !gq_q) ? 10'h001 : per_q + 10'h001;
        pv_q  <= (!rst_n || !supply_ok || restart_req) ? 1'b0 : (pv_q || (gate_drive && !gq_q));
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_live(c);
        gate_drive && (on_q >= 10'd12) && c;
    endsequence
    property p_fb_off; s_live(fb_cmp) |=> !gate_drive; endproperty
    a_fb_off: assert property (p_fb_off) else $error("feedback trip ignored");
    property p_cl_off; s_live(current_limit_comparator) |=> !gate_drive; endproperty
    a_cl_off: assert property (p_cl_off) else $error("current limit ignored");
    property p_bl_off; s_live(burst_limit_comparator && burst_mode) |=> !gate_drive; endproperty
    a_bl_off: assert property (p_bl_off) else $error("burst limit ignored");
    property p_blank; gate_drive && (on_q < 10'd7) && supply_ok && !restart_req |=> gate_drive; endproperty
    a_blank: assert property (p_blank) else $error("pulse cut inside blanking");
    property p_duty; gate_drive |-> on_q < 10'd375; endproperty
    a_duty: assert property (p_duty) else $error("on time above duty cap");
    property p_lockout; !supply_ok |=> !gate_drive ##1 (softstart_limit_level == 5'h00); endproperty
    a_lockout: assert property (p_lockout) else $error("lockout not honoured");
    property p_restart; restart_req |=> ##1 softstart_limit_level == 5'h00; endproperty
    a_restart: assert property (p_restart) else $error("restart kept step");
    property p_step; $changed(softstart_limit_level) && (softstart_limit_level != 5'h00)
        |-> softstart_limit_level == $past(softstart_limit_level) + 5'h01; endproperty
    a_step: assert property (p_step) else $error("step skipped");
    property p_period; gate_drive && !gq_q && pv_q
        |-> (ss_done ? (per_q >= 10'd480 && per_q <= 10'd520) : per_q == 10'd500); endproperty
    a_period: assert property (p_period) else $error("cycle length wrong");
endmodule // cmp_pwm_monitor
bind cmp_pwm_ctrl cmp_pwm_monitor u_mon (.clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
    .restart_req(restart_req), .burst_mode(burst_mode), .fb_cmp(fb_cmp),
    .current_limit_comparator(current_limit_comparator), .burst_limit_comparator(burst_limit_comparator),
    .gate_drive(gate_drive), .softstart_limit_level(softstart_limit_level), .ss_done(ss_done));

// *** bench/test_current_mode_pwm_softstart_ctrl.sv ***
// Purpose: Self-checking bench for the PWM controller
// Assumes: Soft start runs at full length, so only early steps are seen
// Notes:   Widths counted in gate-high cycles at falling edges
module test_current_mode_pwm_softstart_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, supply_ok, restart_req, burst_mode;
    logic       fb_cmp, ss_cmp, cl_cmp, bl_cmp, gate_drive, ss_sink_on, ss_done;
    logic [4:0] lvl;
    logic [1:0] sel;
    logic [9:0] trip;
    int         n_fail, total_checks, w, k;
    cmp_pwm_ctrl dut (.clk(clk), .rst_n(rst_n), .supply_ok(supply_ok), .restart_req(restart_req),
        .burst_mode(burst_mode), .fb_cmp(fb_cmp), .ss_cmp(ss_cmp), .current_limit_comparator(cl_cmp),
        .burst_limit_comparator(bl_cmp), .gate_drive(gate_drive), .softstart_limit_level(lvl),
        .ss_sink_on(ss_sink_on), .ss_done(ss_done), .osc_max_duty());
    cmp_sense_model u_sense (.clk(clk), .gate_drive(gate_drive), .trip_sel(sel), .trip_at(trip),
        .fb_cmp(fb_cmp), .ss_cmp(ss_cmp), .cl_cmp(cl_cmp), .bl_cmp(bl_cmp));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check_val(string what, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // Bounded waits: gate low, then high, then count the high cycles
    task automatic pulse;
        for (k = 0; k < 1000 && gate_drive !== 1'b0; k++) @(negedge clk);
        for (k = 0; k < 1000 && gate_drive !== 1'b1; k++) @(negedge clk);
        if (k == 1000) begin n_fail++; tally_and_finish(); end
        for (w = 0; w < 600 && gate_drive === 1'b1; w++) @(negedge clk);
    endtask
    task automatic trial(string what, logic [1:0] s, logic [9:0] t, logic [15:0] exp);
        @(posedge clk) sel <= s;
        trip <= t;
        pulse();
        pulse();
        check_val(what, exp, w[15:0]);
    endtask
    task automatic t_steps;
        for (k = 0; k < 20000 && lvl !== 5'h01; k++) @(negedge clk);
        for (k = 0; k < 20000 && lvl !== 5'h02; k++) @(negedge clk);
        check_val("step cycles", 16'h3a98, k[15:0]);
    endtask
    task automatic t_normal;
        trial("cap width", 2'h0, 10'h3ff, 16'h0017);
        trial("fb width", 2'h0, 10'h00f, 16'h0010);
        trial("ss width", 2'h2, 10'h00f, 16'h0010);
        trial("blank width", 2'h1, 10'h002, 16'h000c);
        trial("burst lim off", 2'h3, 10'h00f, 16'h0017);
    endtask
    task automatic t_burst;
        @(posedge clk) burst_mode <= 1'b1;
        trial("burst blank", 2'h1, 10'h002, 16'h000a);
        trial("burst lim on", 2'h3, 10'h00f, 16'h0010);
        @(posedge clk) burst_mode <= 1'b0;
    endtask
    task automatic t_period;
        pulse();
        for (k = w; k < 1000 && gate_drive !== 1'b1; k++) @(negedge clk);
        check_val("period", 16'h01f4, k[15:0]);
    endtask
    task automatic t_restart;
        pulse();
        @(posedge clk) restart_req <= 1'b1;
        @(posedge clk) restart_req <= 1'b0;
        repeat (2) @(negedge clk);
        check_val("restart level", 16'h0000, {11'h000, lvl});
    endtask
    task automatic t_lockout;
        @(posedge clk) supply_ok <= 1'b0;
        repeat (3) @(negedge clk);
        check_val("lockout gate", 16'h0000, {15'h0000, gate_drive});
        check_val("lockout level", 16'h0000, {11'h000, lvl});
        @(posedge clk) supply_ok <= 1'b1;
        repeat (3) @(negedge clk);
        check_val("sink on", 16'h0001, {15'h0000, ss_sink_on});
    endtask
    // Main sequence
    initial begin
        {rst_n, restart_req, burst_mode, sel} = '0;
        supply_ok = 1'b1;
        trip = 10'h3ff;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        check_val("done at start", 16'h0000, {15'h0000, ss_done});
        t_steps();
        t_normal();
        t_burst();
        @(posedge clk) trip <= 10'h3ff;
        t_period();
        t_restart();
        t_lockout();
        tally_and_finish();
    end
endmodule // test_current_mode_pwm_softstart_ctrl
